// >>> common/lbic_cfg.svh
// constants for the led bank brightness controller
`ifndef LBIC_CFG_SVH
`define LBIC_CFG_SVH
`define LBIC_ADDR_STD     7'h36
`define LBIC_ADDR_ALT     7'h38
`define LBIC_OFS_GPR      8'h10
`define LBIC_OFS_MAIN     8'ha0
`define LBIC_OFS_AUX      8'hb0
`define LBIC_OFS_IND      8'hc0
`define LBIC_RST_GPR      8'h20
`define LBIC_RST_MAIN     8'he0
`define LBIC_RST_AUX      8'he0
`define LBIC_RST_IND      8'hfc
`define LBIC_UNUSED_MAIN  3'h7
`define LBIC_UNUSED_IND   6'h3f
`define LBIC_BIT_MAIN_EN  0
`define LBIC_BIT_AUX_EN   1
`define LBIC_BIT_IND_EN   2
`define LBIC_BIT_FIFTH    3
`define LBIC_BIT_THIRD    4
`define LBIC_CLK_HZ       125000000
`define LBIC_PWM_HZ       20000
`define LBIC_DUTY_STEPS   16
`define LBIC_STEP_20      2'h0
`define LBIC_STEP_40      2'h1
`define LBIC_STEP_70      2'h2
`define LBIC_STEP_100     2'h3
`define LBIC_ACK_BIT      4'h8
`define LBIC_LAST_BIT     4'h7
`define LBIC_BIT_ARM      4'hf
`endif

// >>> common/lbic_pkg.sv
// types for the led bank brightness controller
package lbic_pkg;
   typedef struct packed {
      logic [7:0] gpr;
      logic [7:0] main_lvl;
      logic [7:0] aux_lvl;
      logic [7:0] ind_lvl;
   } lbic_regs_t;

   typedef struct packed {
      logic       main_sink_on;
      logic [1:0] main_step;
      logic       fifth_main_sense_on;
      logic       aux_sink_on;
      logic [1:0] aux_step;
      logic       third_aux_sink_on;
      logic       indicator_sink_on;
      logic [1:0] indicator_step;
   } lbic_drive_t;

   typedef struct packed {
      logic [1:0] step;
      logic [4:0] duty;
   } lbic_level_t;

   typedef enum logic [2:0] {S_IDLE, S_ADDR, S_PTR, S_DATA, S_READ} lbic_state_t;
endpackage

// >>> rtl/lbic_top.sv
// two-wire slave, control registers and bank dimming for the led driver
`timescale 1ns/100ps
`include "lbic_cfg.svh"
module lbic_top #(
   parameter int   PWM_PERIOD_CYC = `LBIC_CLK_HZ / `LBIC_PWM_HZ,
   parameter logic ALT_ADDRESS    = 1'b0
) (
   input  wire logic                 CLK,
   input  wire logic                 SRST,
   input  wire logic                 LINK_CLK,
   input  wire logic                 RESET_N,
   input  wire logic                 SCL,
   input  wire logic                 SDA_I,
   output logic                      SDA_O,
   output logic                      SDA_OE,
   output lbic_pkg::lbic_drive_t     LED
);
   import lbic_pkg::*;

   localparam logic [6:0] OWN_ADDR = ALT_ADDRESS ? `LBIC_ADDR_ALT : `LBIC_ADDR_STD;
   localparam lbic_regs_t REGS_RST = {`LBIC_RST_GPR, `LBIC_RST_MAIN, `LBIC_RST_AUX,
                                      `LBIC_RST_IND};

   // ----------------------------------------------------------------
   // register access helpers
   // ----------------------------------------------------------------
   function automatic lbic_regs_t reg_write(input lbic_regs_t r, input logic [7:0] ptr,
                                            input logic [7:0] d);
      lbic_regs_t n;
      n = r;
      unique case (ptr)
         `LBIC_OFS_GPR:  n.gpr = d;
         `LBIC_OFS_MAIN: n.main_lvl = {`LBIC_UNUSED_MAIN, d[4:0]};
         `LBIC_OFS_AUX:  n.aux_lvl = {`LBIC_UNUSED_MAIN, d[4:0]};
         `LBIC_OFS_IND:  n.ind_lvl = {`LBIC_UNUSED_IND, d[1:0]};
         default:        n = r;
      endcase
      return n;
   endfunction

   function automatic logic [7:0] reg_read(input lbic_regs_t r, input logic [7:0] ptr);
      logic [7:0] v;
      v = 8'h00;
      unique case (ptr)
         `LBIC_OFS_GPR:  v = r.gpr;
         `LBIC_OFS_MAIN: v = r.main_lvl;
         `LBIC_OFS_AUX:  v = r.aux_lvl;
         `LBIC_OFS_IND:  v = r.ind_lvl;
         default:        v = 8'h00;
      endcase
      return v;
   endfunction

   // ----------------------------------------------------------------
   // link domain: reset and pin synchronisers
   // ----------------------------------------------------------------
   logic lrst_s1_reg, link_rst;
   logic scl_s1_reg, scl_s2_reg, scl_s3_reg;
   logic sda_s1_reg, sda_s2_reg, sda_s3_reg;

   always_ff @(posedge LINK_CLK) begin
      lrst_s1_reg <= SRST | ~RESET_N;
      link_rst    <= lrst_s1_reg;
   end

   always_ff @(posedge LINK_CLK) begin
      if (link_rst) begin
         {scl_s1_reg, scl_s2_reg, scl_s3_reg} <= 3'h7;
         {sda_s1_reg, sda_s2_reg, sda_s3_reg} <= 3'h7;
      end else begin
         {scl_s1_reg, scl_s2_reg, scl_s3_reg} <= {SCL, scl_s1_reg, scl_s2_reg};
         {sda_s1_reg, sda_s2_reg, sda_s3_reg} <= {SDA_I, sda_s1_reg, sda_s2_reg};
      end
   end

   logic scl_rise, scl_fall, start_ev, stop_ev;
   assign scl_rise = scl_s2_reg & ~scl_s3_reg;
   assign scl_fall = ~scl_s2_reg & scl_s3_reg;
   assign start_ev = scl_s2_reg & scl_s3_reg & sda_s3_reg & ~sda_s2_reg;
   assign stop_ev  = scl_s2_reg & scl_s3_reg & ~sda_s3_reg & sda_s2_reg;

   // ----------------------------------------------------------------
   // link domain: serial slave
   // ----------------------------------------------------------------
   lbic_state_t st_reg, st_next;
   logic [3:0]  bit_reg, bit_next;
   logic [7:0]  rx_reg, rx_next, tx_reg, tx_next, ptr_reg, ptr_next;
   logic        rw_reg, rw_next, mack_reg, mack_next, oe_reg, oe_next;
   logic        tog_reg, tog_next, sda_o_reg;
   lbic_regs_t  regs_reg, regs_next;
   logic [7:0]  rd_byte;

   assign rd_byte = reg_read(regs_reg, ptr_reg);

   always_comb begin
      st_next   = st_reg;
      bit_next  = bit_reg;
      rx_next   = rx_reg;
      tx_next   = tx_reg;
      ptr_next  = ptr_reg;
      rw_next   = rw_reg;
      mack_next = mack_reg;
      oe_next   = oe_reg;
      regs_next = regs_reg;
      tog_next  = tog_reg;
      if (stop_ev) begin
         st_next = S_IDLE;
         oe_next = 1'b0;
      end else if (start_ev) begin
         st_next  = S_ADDR;
         // clock fall closing the start only arms the count
         bit_next = `LBIC_BIT_ARM;
         oe_next  = 1'b0;
      end else if (st_reg != S_IDLE) begin
         if (scl_rise) begin
            if (bit_reg == `LBIC_ACK_BIT) begin
               mack_next = ~sda_s2_reg;
            end else begin
               rx_next = {rx_reg[6:0], sda_s2_reg};
            end
         end
         if (scl_fall) begin
            bit_next = (bit_reg == `LBIC_ACK_BIT) ? 4'h0 : bit_reg + 4'h1;
            oe_next  = 1'b0;
            if (bit_reg == `LBIC_LAST_BIT) begin
               unique case (st_reg)
                  S_ADDR: begin
                     if (rx_reg[7:1] == OWN_ADDR) begin
                        oe_next = 1'b1;
                        rw_next = rx_reg[0];
                     end else begin
                        st_next = S_IDLE;
                     end
                  end
                  S_PTR: begin
                     oe_next  = 1'b1;
                     ptr_next = rx_reg;
                  end
                  S_DATA: begin
                     oe_next   = 1'b1;
                     regs_next = reg_write(regs_reg, ptr_reg, rx_reg);
                     tog_next  = ~tog_reg;
                  end
                  S_READ, S_IDLE: oe_next = 1'b0;
               endcase
            end else if (bit_reg == `LBIC_ACK_BIT) begin
               unique case (st_reg)
                  S_ADDR: begin
                     if (rw_reg) begin
                        st_next = S_READ;
                        oe_next = ~rd_byte[7];
                        tx_next = {rd_byte[6:0], 1'b0};
                     end else begin
                        st_next = S_PTR;
                     end
                  end
                  S_PTR: st_next = S_DATA;
                  S_READ: begin
                     if (mack_reg) begin
                        oe_next = ~rd_byte[7];
                        tx_next = {rd_byte[6:0], 1'b0};
                     end else begin
                        st_next = S_IDLE;
                     end
                  end
                  S_DATA, S_IDLE: st_next = st_reg;
               endcase
            end else if (st_reg == S_READ) begin
               oe_next = ~tx_reg[7];
               tx_next = {tx_reg[6:0], 1'b0};
            end
         end
      end
   end

   always_ff @(posedge LINK_CLK) begin
      if (link_rst) begin
         st_reg    <= S_IDLE;
         bit_reg   <= 4'h0;
         rx_reg    <= 8'h00;
         tx_reg    <= 8'h00;
         ptr_reg   <= 8'h00;
         rw_reg    <= 1'b0;
         mack_reg  <= 1'b0;
         oe_reg    <= 1'b0;
         regs_reg  <= REGS_RST;
         tog_reg   <= 1'b0;
         sda_o_reg <= 1'b0;
      end else begin
         st_reg    <= st_next;
         bit_reg   <= bit_next;
         rx_reg    <= rx_next;
         tx_reg    <= tx_next;
         ptr_reg   <= ptr_next;
         rw_reg    <= rw_next;
         mack_reg  <= mack_next;
         oe_reg    <= oe_next;
         regs_reg  <= regs_next;
         tog_reg   <= tog_next;
         sda_o_reg <= 1'b0;
      end
   end

   assign SDA_O  = sda_o_reg;
   assign SDA_OE = oe_reg;

   // ----------------------------------------------------------------
   // core domain: reset, register crossing, dimming
   // ----------------------------------------------------------------
   logic rstn_s1_reg, rstn_s2_reg, clk_rst;
   logic tog_s1_reg, tog_s2_reg, tog_s3_reg;

   always_ff @(posedge CLK) begin
      if (SRST) begin
         {rstn_s1_reg, rstn_s2_reg} <= 2'h0;
      end else begin
         {rstn_s1_reg, rstn_s2_reg} <= {RESET_N, rstn_s1_reg};
      end
   end
   assign clk_rst = SRST | ~rstn_s2_reg;

   always_ff @(posedge CLK) begin
      if (clk_rst) begin
         {tog_s1_reg, tog_s2_reg, tog_s3_reg} <= 3'h0;
      end else begin
         {tog_s1_reg, tog_s2_reg, tog_s3_reg} <= {tog_reg, tog_s1_reg, tog_s2_reg};
      end
   end

   function automatic lbic_level_t lvl_decode(input logic [4:0] c);
      lbic_level_t l;
      l = '0;
      if (c < 5'h10) begin
         l.step = `LBIC_STEP_20;
         l.duty = c + 5'h01;
      end else if (c < 5'h17) begin
         l.step = `LBIC_STEP_40;
         l.duty = c - 5'h06;
      end else if (c < 5'h1d) begin
         l.step = `LBIC_STEP_70;
         l.duty = c - 5'h0c;
      end else begin
         l.step = `LBIC_STEP_100;
         l.duty = (c == 5'h1d) ? 5'h0d : (c == 5'h1e) ? 5'h0f : 5'h10;
      end
      return l;
   endfunction

   logic [12:0] cnt_reg, cnt_next;
   lbic_regs_t  shadow_reg, shadow_next;
   lbic_drive_t drv_reg, drv_next;

   function automatic logic pwm_high(input logic [4:0] duty, input logic [12:0] cnt);
      logic [31:0] lhs, rhs;
      lhs = 32'(cnt) * 32'(`LBIC_DUTY_STEPS);
      rhs = 32'(duty) * 32'(PWM_PERIOD_CYC);
      return lhs < rhs;
   endfunction

   always_comb begin
      lbic_level_t m, a;
      logic [7:0]  g;
      m = lvl_decode(shadow_reg.main_lvl[4:0]);
      a = lvl_decode(shadow_reg.aux_lvl[4:0]);
      g = shadow_reg.gpr;
      shadow_next = (tog_s2_reg != tog_s3_reg) ? regs_reg : shadow_reg;
      cnt_next = (cnt_reg == 13'(PWM_PERIOD_CYC - 1)) ? 13'h0 : cnt_reg + 13'h1;
      drv_next.main_sink_on        = g[`LBIC_BIT_MAIN_EN] & pwm_high(m.duty, cnt_reg);
      drv_next.main_step           = m.step;
      drv_next.fifth_main_sense_on = g[`LBIC_BIT_MAIN_EN] & g[`LBIC_BIT_FIFTH];
      drv_next.aux_sink_on         = g[`LBIC_BIT_AUX_EN] & pwm_high(a.duty, cnt_reg);
      drv_next.aux_step            = a.step;
      drv_next.third_aux_sink_on   = drv_next.aux_sink_on & g[`LBIC_BIT_THIRD];
      drv_next.indicator_sink_on   = g[`LBIC_BIT_IND_EN];
      drv_next.indicator_step      = shadow_reg.ind_lvl[1:0];
   end

   always_ff @(posedge CLK) begin
      if (clk_rst) begin
         cnt_reg    <= 13'h0;
         shadow_reg <= REGS_RST;
         drv_reg    <= '0;
      end else begin
         cnt_reg    <= cnt_next;
         shadow_reg <= shadow_next;
         drv_reg    <= drv_next;
      end
   end

   assign LED = drv_reg;

   // ----------------------------------------------------------------
   // assertions
   // ----------------------------------------------------------------
   logic quiet;
   assign quiet = ~start_ev & ~stop_ev & scl_fall;

   a_ack_own_addr: assert property (@(posedge LINK_CLK) disable iff (link_rst)
      (quiet && st_reg == S_ADDR && bit_reg == 4'h7 && rx_reg[7:1] == OWN_ADDR)
      |=> oe_reg ##1 oe_reg [*3]) else $error("no acknowledge of own address");
   a_foreign_ignored: assert property (@(posedge LINK_CLK) disable iff (link_rst)
      (quiet && st_reg == S_ADDR && bit_reg == 4'h7 && rx_reg[7:1] != OWN_ADDR)
      |=> !oe_reg && st_reg == S_IDLE) else $error("foreign address answered");
   a_restart_same: assert property (@(posedge LINK_CLK) disable iff (link_rst)
      (start_ev && !stop_ev) |=> st_reg == S_ADDR && bit_reg == `LBIC_BIT_ARM)
      else $error("start not taken");
   a_drive_on_low: assert property (@(posedge LINK_CLK) disable iff (link_rst)
      $rose(oe_reg) |-> $past(scl_fall)) else $error("data pulled while clock high");
   a_write_stores: assert property (@(posedge LINK_CLK) disable iff (link_rst)
      (quiet && st_reg == S_DATA && bit_reg == 4'h7 && ptr_reg == `LBIC_OFS_MAIN)
      |=> regs_reg.main_lvl == {`LBIC_UNUSED_MAIN, $past(rx_reg[4:0])})
      else $error("write not stored");
   a_read_msb: assert property (@(posedge LINK_CLK) disable iff (link_rst)
      (quiet && st_reg == S_ADDR && rw_reg && bit_reg == `LBIC_ACK_BIT)
      |=> oe_reg == ~$past(rd_byte[7]) && st_reg == S_READ) else $error("bad read bit");
   a_unused_ones: assert property (@(posedge CLK) disable iff (clk_rst)
      shadow_reg.main_lvl[7:5] == `LBIC_UNUSED_MAIN && shadow_reg.ind_lvl[7:2] ==
      `LBIC_UNUSED_IND) else $error("unused bits not one");
   a_full_scale: assert property (@(posedge CLK) disable iff (clk_rst)
      (shadow_reg.main_lvl[4:0] == 5'h1f && shadow_reg.gpr[`LBIC_BIT_MAIN_EN])
      |=> LED.main_sink_on && LED.main_step == `LBIC_STEP_100) else $error("not full");
   a_low_codes: assert property (@(posedge CLK) disable iff (clk_rst)
      (shadow_reg.aux_lvl[4:0] == 5'h00 && cnt_reg > 13'(PWM_PERIOD_CYC / 16))
      |=> !LED.aux_sink_on && LED.aux_step == `LBIC_STEP_20) else $error("bad low duty");
   a_pwm_wrap: assert property (@(posedge CLK) disable iff (clk_rst)
      (cnt_reg == 13'(PWM_PERIOD_CYC - 1)) |=> cnt_reg == 13'h0) else $error("bad period");
   a_reset_dark: assert property (@(posedge CLK) disable iff (SRST)
      !rstn_s2_reg |=> !LED.main_sink_on && !LED.aux_sink_on && !LED.indicator_sink_on)
      else $error("outputs lit in reset");
   c_start: cover property (@(posedge LINK_CLK) disable iff (link_rst) start_ev);
   c_write: cover property (@(posedge LINK_CLK) disable iff (link_rst) $changed(tog_reg));
   c_read: cover property (@(posedge LINK_CLK) disable iff (link_rst)
      st_reg == S_ADDR ##1 st_reg == S_READ);
   c_full: cover property (@(posedge CLK) disable iff (clk_rst)
      LED.main_step == `LBIC_STEP_100 && LED.main_sink_on);
endmodule // lbic_top

// >>> verification/lbic_master.sv
// two-wire bus master model that drives the controller's serial pins
`timescale 1ns/100ps
module lbic_master (
   input  wire logic LINK_CLK,
   input  wire logic SDA_IN,
   output logic      SCL,
   output logic      SDA_PULL
);
   // -------------------------------------
   // bus conditions, pins move on falling link edge
   // -------------------------------------
   initial begin
      SCL      = 1'b1;
      SDA_PULL = 1'b0;
   end
   task automatic hold(input int n);
      repeat (n) @(negedge LINK_CLK);
   endtask
   // also serves as repeated start
   task automatic start();
      SDA_PULL = 1'b0;
      hold(5);
      SCL = 1'b1;
      hold(5);
      SDA_PULL = 1'b1;
      hold(5);
      SCL = 1'b0;
      hold(5);
   endtask
   task automatic stop();
      SDA_PULL = 1'b1;
      hold(5);
      SCL = 1'b1;
      hold(5);
      SDA_PULL = 1'b0;
      hold(5);
   endtask
   task automatic bit_io(input logic b, output logic r);
      SDA_PULL = ~b;
      hold(5);
      SCL = 1'b1;
      hold(5);
      r   = SDA_IN;
      SCL = 1'b0;
   endtask
   // give_ack low releases the line on the ninth pulse
   task automatic xfer(input logic [7:0] d, input logic give_ack,
                       output logic [7:0] r, output logic ack);
      for (int i = 7; i >= 0; i--) bit_io(d[i], r[i]);
      bit_io(~give_ack, ack);
      ack = ~ack;
   endtask
endmodule // lbic_master

// >>> verification/test_led_bank_i2c_brightness_ctrl.sv
// self-checking bench for the led bank brightness controller
`timescale 1ns/100ps
`include "lbic_cfg.svh"
module test_led_bank_i2c_brightness_ctrl;
   import lbic_pkg::*;
   localparam int PER = 64;
   logic        clk      = 1'b0;
   logic        link_clk = 1'b0;
   logic        srst     = 1'b1;
   logic        reset_n  = 1'b1;
   logic        scl, sda_pull, sda_o, sda_oe, scl_q, oe_q;
   wire         sda      = ~(sda_pull | sda_oe);
   lbic_drive_t led;
   int          n_errors = 0;
   int          n_checks = 0;
   logic [7:0]  ofs  [4] = '{8'h10, 8'ha0, 8'hb0, 8'hc0};
   logic [7:0]  dflt [4] = '{8'h20, 8'he0, 8'he0, 8'hfc};
   logic [7:0]  ones [4] = '{8'h00, 8'he0, 8'he0, 8'hfc};

   always #4 clk = ~clk;
   initial begin
      #1.3;
      forever #6 link_clk = ~link_clk;
   end

   lbic_top #(.PWM_PERIOD_CYC(PER), .ALT_ADDRESS(1'b0)) dut (
      .CLK(clk), .SRST(srst), .LINK_CLK(link_clk), .RESET_N(reset_n), .SCL(scl),
      .SDA_I(sda), .SDA_O(sda_o), .SDA_OE(sda_oe), .LED(led));
   lbic_master m (.LINK_CLK(link_clk), .SDA_IN(sda), .SCL(scl), .SDA_PULL(sda_pull));

   // data line must hold while clock is high
   always @(posedge link_clk) begin
      if (scl && scl_q && sda_oe !== oe_q) begin
         n_errors++;
         $display("unexpected data change: expected %b, seen %b", oe_q, sda_oe);
      end
      scl_q <= scl;
      oe_q  <= sda_oe;
   end

   // -------------------------------------
   // helpers
   // -------------------------------------
   task automatic chk(input string what, input logic [7:0] exp, input logic [7:0] got);
      n_checks++;
      if (got !== exp) begin
         n_errors++;
         $display("unexpected %s: expected %h, seen %h", what, exp, got);
      end
   endtask
   task automatic wr(input logic [7:0] ptr, input logic [7:0] d);
      logic [7:0] r;
      logic       a0, a1, a2;
      m.start();
      m.xfer({`LBIC_ADDR_STD, 1'b0}, 1'b0, r, a0);
      m.xfer(ptr, 1'b0, r, a1);
      m.xfer(d, 1'b0, r, a2);
      m.stop();
      chk("write acks", 8'h07, {5'h0, a0, a1, a2});
      chk("data out level", 8'h00, {7'h0, sda_o});
   endtask
   task automatic rd(input logic [7:0] ptr, output logic [7:0] d);
      logic [7:0] r;
      logic       a0, a1, a2, a3;
      m.start();
      m.xfer({`LBIC_ADDR_STD, 1'b0}, 1'b0, r, a0);
      m.xfer(ptr, 1'b0, r, a1);
      m.start();
      m.xfer({`LBIC_ADDR_STD, 1'b1}, 1'b0, r, a2);
      m.xfer(8'hff, 1'b0, d, a3);
      m.stop();
      chk("read acks", 8'h0e, {4'h0, a0, a1, a2, a3});
   endtask
   function automatic lbic_level_t lvl(input int c);
      lvl.step = (c < 16) ? 2'h0 : (c < 23) ? 2'h1 : (c < 29) ? 2'h2 : 2'h3;
      lvl.duty = (c < 16) ? 5'(c + 1) : (c < 23) ? 5'(c - 6) : (c < 29) ? 5'(c - 12)
               : (c == 29) ? 5'd13 : (c == 30) ? 5'd15 : 5'd16;
   endfunction

   // -------------------------------------
   // scenarios
   // -------------------------------------
   task automatic t_defaults(input string name);
      logic [7:0] d;
      for (int i = 0; i < 4; i++) begin
         rd(ofs[i], d);
         chk("reset value", dflt[i], d);
      end
      $display("test %s done", name);
   endtask
   task automatic t_access();
      logic [7:0] d;
      logic [7:0] v [2] = '{8'h00, 8'h35};
      for (int i = 0; i < 4; i++) begin
         for (int j = 0; j < 2; j++) begin
            wr(ofs[i], v[j]);
            rd(ofs[i], d);
            chk("readback", ones[i] | v[j], d);
         end
      end
      $display("test access done");
   endtask
   task automatic t_address();
      logic [7:0] r, d;
      logic       a0, a1;
      wr(8'h10, 8'h05);
      m.start();
      m.xfer({`LBIC_ADDR_ALT, 1'b0}, 1'b0, r, a0);
      m.xfer(8'h10, 1'b0, r, a1);
      m.xfer(8'hff, 1'b0, r, a1);
      m.stop();
      chk("foreign ack", 8'h00, {7'h0, a0});
      rd(8'h10, d);
      chk("gpr kept", 8'h05, d);
      wr(8'h20, 8'h55);
      rd(8'h20, d);
      chk("unmapped read", 8'h00, d);
      $display("test address done");
   endtask
   task automatic t_levels();
      lbic_level_t ea, eb;
      int          na, nb;
      wr(8'h10, 8'h03);
      for (int c = 0; c < 32; c++) begin
         wr(8'ha0, 8'(c));
         wr(8'hb0, 8'(31 - c));
         ea = lvl(c);
         eb = lvl(31 - c);
         na = 0;
         nb = 0;
         repeat (6) @(negedge clk);
         for (int k = 0; k < PER; k++) begin
            @(negedge clk);
            na += int'(led.main_sink_on);
            nb += int'(led.aux_sink_on);
         end
         chk("main step", 8'(ea.step), 8'(led.main_step));
         chk("aux step", 8'(eb.step), 8'(led.aux_step));
         chk("main duty", 8'(ea.duty * PER / 16), 8'(na));
         chk("aux duty", 8'(eb.duty * PER / 16), 8'(nb));
      end
      $display("test levels done");
   endtask
   task automatic t_enables();
      logic [4:0] g;
      int         n;
      wr(8'ha0, 8'h1f);
      wr(8'hb0, 8'h1f);
      for (int i = 0; i < 32; i++) begin
         g = 5'(i);
         wr(8'h10, {3'h0, g});
         repeat (6) @(negedge clk);
         chk("sink enables", {3'h0, g[0], g[0] & g[3], g[1], g[1] & g[4], g[2]},
             {3'h0, led.main_sink_on, led.fifth_main_sense_on, led.aux_sink_on,
              led.third_aux_sink_on, led.indicator_sink_on});
      end
      for (int c = 0; c < 4; c++) begin
         wr(8'hc0, 8'(c));
         repeat (6) @(negedge clk);
         n = 0;
         for (int k = 0; k < PER; k++) begin
            @(negedge clk);
            n += int'(led.indicator_sink_on);
         end
         chk("indicator step", 8'(c), 8'(led.indicator_step));
         chk("indicator on time", 8'(PER), 8'(n));
      end
      $display("test enables done");
   endtask
   task automatic t_hwreset();
      reset_n = 1'b0;
      repeat (8) @(negedge clk);
      chk("led in reset", 8'h00, {7'h0, |led});
      reset_n = 1'b1;
      repeat (10) @(negedge clk);
      chk("led after reset", 8'h00, {7'h0, |led});
      t_defaults("hardware reset");
   endtask

   // -------------------------------------
   // run control
   // -------------------------------------
   task automatic give_verdict();
      $display("checks %0d, mismatches %0d", n_checks, n_errors);
      if (n_errors == 0 && n_checks > 0)
         $display("Regression OK");
      else
         $display("Regression broken");
      $finish;
   endtask
   initial begin
      #700000;
      n_errors++;
      $display("unexpected watchdog: expected end of tests, seen none");
      give_verdict();
   end
   initial begin
      repeat (16) @(negedge clk);
      srst = 1'b0;
      repeat (10) @(negedge clk);
      chk("led dark", 8'h00, {7'h0, |led});
      t_defaults("reset defaults");
      t_access();
      t_address();
      t_levels();
      t_enables();
      t_hwreset();
      give_verdict();
   end
endmodule // test_led_bank_i2c_brightness_ctrl
